// [hdl/sfp_map.svh]
// Register offsets, field positions, reset values and timing counts.
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH

`define SFP_OFF_CTRL        12'h000
`define SFP_OFF_VCE_BLANK   12'h004
`define SFP_OFF_OC_BLANK    12'h008
`define SFP_OFF_FLAGS       12'h00C
`define SFP_OFF_FLAG_CLR    12'h010
`define SFP_OFF_IRQ_EN      12'h014
`define SFP_OFF_LIVE        12'h018

`define SFP_CTRL_VCE_LVL    0
`define SFP_CTRL_VCE_CLAMP  1
`define SFP_CTRL_OC_LVL_LO  2
`define SFP_CTRL_OC_LVL_HI  3
`define SFP_CTRL_REARM      8

`define SFP_FLAG_VCE        0
`define SFP_FLAG_OC         1
`define SFP_FLAG_PERMIT     2

`define SFP_LIVE_VCE_CMP    0
`define SFP_LIVE_OC_CMP     1
`define SFP_LIVE_PERMIT     2
`define SFP_LIVE_DISABLED   3

`define SFP_CTRL_RESET      4'h0
`define SFP_BLANK_RESET     8'h10
`define SFP_IRQ_EN_RESET    3'h0

`define SFP_CLK_PERIOD_NS   4
`define SFP_BLANK_UNIT_NS   100
`define SFP_BLANK_UNIT_CYC  (`SFP_BLANK_UNIT_NS / `SFP_CLK_PERIOD_NS)

`endif

// [hdl/sfp_pkg.sv]
// Types shared by the fault protection modules.
package sfp_pkg;

    typedef logic [7:0] sfp_blank_t;

    typedef enum logic [2:0]
    {
        SFP_REG_CTRL,
        SFP_REG_VCE_BLANK,
        SFP_REG_OC_BLANK,
        SFP_REG_FLAGS,
        SFP_REG_FLAG_CLR,
        SFP_REG_IRQ_EN,
        SFP_REG_LIVE,
        SFP_REG_NONE
    } sfp_reg_e;

endpackage

// [hdl/sfp_blank_if.sv]
// Start, period and busy signals between the top and a blanking timer.
interface sfp_blank_if;
    logic               start;
    sfp_pkg::sfp_blank_t period;
    logic               busy;

    modport owner (output start, output period, input busy);
    modport timer (input start, input period, output busy);
endinterface

// [hdl/sfp_blank_timer.sv]
// Blanking interval timer counted in units of the blanking tick.
`include "sfp_map.svh"

module sfp_blank_timer
(
    input  wire logic i_clock, // System clock.
    input  wire logic i_rst_b, // Asynchronous reset, active low.
    sfp_blank_if.timer bus     // Start, period and busy.
);

    localparam int UNIT = `SFP_BLANK_UNIT_CYC;

    logic [4:0]          pre_q;
    sfp_pkg::sfp_blank_t cnt_q;

    // A start reloads the count and restarts the tick divider.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_q <= 8'h00;
            pre_q <= 5'h00;
        end
        else if (bus.start)
        begin
            cnt_q <= bus.period; // see RULE_18
            pre_q <= 5'h00;
        end
        else if (cnt_q != 8'h00)
        begin
            if (pre_q == 5'(UNIT - 1))
            begin
                pre_q <= 5'h00;
                cnt_q <= cnt_q - 8'h01;
            end
            else
            begin
                pre_q <= pre_q + 5'h01;
            end
        end
    end

    assign bus.busy = (cnt_q != 8'h00);

endmodule

// [hdl/sfp_protect.sv]
// Category A switch fault protection with APB registers.
// Summary of operation
// RULE_01: Hold sense pin low during turn-on blanking.
// RULE_02: Saturation above threshold trips safe turn-off.
// RULE_03: Saturation level select writable in configuration only.
// RULE_04: No saturation supervision while output is off.
// RULE_05: Live saturation comparator readable.
// RULE_06: Turn-off hold covers plateau plus blanking.
// RULE_07: Clamp sense pin while off when enabled.
// RULE_08: Ignore overcurrent comparison during its blanking.
// RULE_09: Overcurrent above threshold trips safe turn-off.
// RULE_10: No overcurrent supervision while output is off.
// RULE_11: Overcurrent status masked during blanking.
// RULE_12: Overcurrent threshold chosen by level field.
// RULE_13: Open current sense input counts as fault.
// RULE_14: Both supervisions run independently together.
// RULE_15: Permit loss trips regular turn-off.
// RULE_16: Live external permit validity readable.
// RULE_17: Stay disabled until software reactivates.
// RULE_18: Blanking counters reload at every turn-on.
//
// Added by the designer: the placing of the registers and the APB slave port.
`include "sfp_map.svh"

module sfp_protect
(
    input  wire logic        i_clock,          // 250 MHz clock.
    input  wire logic        i_rst_b,          // Async reset, low.
    input  wire logic        i_psel,           // APB select.
    input  wire logic        i_penable,        // APB enable.
    input  wire logic        i_pwrite,         // APB write.
    input  wire logic [11:0] i_paddr,          // APB byte address.
    input  wire logic [31:0] i_pwdata,         // APB write data.
    output logic      [31:0] o_prdata,         // APB read data.
    output logic             o_pready,         // APB ready.
    output logic             o_pslverr,        // APB error.
    input  wire logic        i_pwm_on,         // PWM on command.
    input  wire logic        i_two_level_turnoff, // Plateau active.
    input  wire logic        i_hard_off_start, // Hard turn-off pulse.
    input  wire logic        i_config_op_state, // Configuration state.
    input  wire logic        i_vce_cmp,        // Saturation comparator.
    input  wire logic        i_oc_cmp,         // Overcurrent comparator.
    input  wire logic        i_ext_permit,     // External permit pin.
    output logic             o_vce_sense_clamp, // Pull sense pin low.
    output logic             o_vce_level_select, // Saturation level.
    output logic       [1:0] o_oc_level_select, // Overcurrent level.
    output logic             o_safe_off_req,   // Safe turn-off pulse.
    output logic             o_regular_off_req, // Regular off pulse.
    output logic             o_fault_a_out_b,  // Fault output, low.
    output logic             o_disabled,       // Driver disabled.
    output logic             o_irq             // Interrupt, high.
);

    sfp_blank_if vce_on_if ();
    sfp_blank_if vce_off_if ();
    sfp_blank_if oc_on_if ();

    logic [1:0]          vce_sync_q;
    logic [1:0]          oc_sync_q;
    logic [1:0]          permit_sync_q;
    logic                permit_prev_q;
    logic                pwm_prev_q;
    logic [3:0]          ctrl_q;
    sfp_pkg::sfp_blank_t vce_blank_q;
    sfp_pkg::sfp_blank_t oc_blank_q;
    logic [2:0]          flags_q;
    logic [2:0]          irq_en_q;
    logic                disabled_q;
    logic                turn_on;
    logic                vce_blanking;
    logic                oc_blanking;
    logic                vce_hold_d;
    logic                vce_fault;
    logic                oc_fault;
    logic                permit_loss;
    logic [2:0]          events;
    logic                wr_en;
    logic                rd_en;
    logic                rearm;
    sfp_pkg::sfp_reg_e   sel;
    logic [31:0]         rd_d;

    function automatic sfp_pkg::sfp_reg_e decode(input logic [11:0] a);
        unique case (a)
            `SFP_OFF_CTRL:      decode = sfp_pkg::SFP_REG_CTRL;
            `SFP_OFF_VCE_BLANK: decode = sfp_pkg::SFP_REG_VCE_BLANK;
            `SFP_OFF_OC_BLANK:  decode = sfp_pkg::SFP_REG_OC_BLANK;
            `SFP_OFF_FLAGS:     decode = sfp_pkg::SFP_REG_FLAGS;
            `SFP_OFF_FLAG_CLR:  decode = sfp_pkg::SFP_REG_FLAG_CLR;
            `SFP_OFF_IRQ_EN:    decode = sfp_pkg::SFP_REG_IRQ_EN;
            `SFP_OFF_LIVE:      decode = sfp_pkg::SFP_REG_LIVE;
            default:            decode = sfp_pkg::SFP_REG_NONE;
        endcase
    endfunction

    // Pin comparator outputs and the permit pin are synchronised.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            vce_sync_q    <= 2'h0;
            oc_sync_q     <= 2'h3;
            permit_sync_q <= 2'h0;
        end
        else
        begin
            vce_sync_q    <= {vce_sync_q[0], i_vce_cmp};
            oc_sync_q     <= {oc_sync_q[0], i_oc_cmp};
            permit_sync_q <= {permit_sync_q[0], i_ext_permit};
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pwm_prev_q    <= 1'b0;
            permit_prev_q <= 1'b0;
        end
        else
        begin
            pwm_prev_q    <= i_pwm_on;
            permit_prev_q <= permit_sync_q[1];
        end
    end

    assign turn_on = i_pwm_on & ~pwm_prev_q;

    // Each turn-on restarts both turn-on blanking timers, not the hard-off one.
    assign vce_on_if.start   = turn_on; // see RULE_18
    assign vce_on_if.period  = vce_blank_q;
    assign oc_on_if.start    = turn_on; // see RULE_18
    assign oc_on_if.period   = oc_blank_q;
    assign vce_off_if.start  = i_hard_off_start; // see RULE_06
    assign vce_off_if.period = vce_blank_q;

    sfp_blank_timer u_vce_on
    (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .bus     (vce_on_if.timer)
    );

    sfp_blank_timer u_vce_off
    (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .bus     (vce_off_if.timer)
    );

    sfp_blank_timer u_oc_on
    (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .bus     (oc_on_if.timer)
    );

    assign vce_blanking = turn_on | vce_on_if.busy; // see RULE_01
    assign oc_blanking  = turn_on | oc_on_if.busy;  // see RULE_08

    // The sense pin is held low while blanking, on the plateau, during
    // the post hard-off extension, and while off with clamping enabled.
    always_comb
    begin
        vce_hold_d = vce_blanking; // see RULE_01
        if (i_two_level_turnoff | vce_off_if.start | vce_off_if.busy)
        begin
            vce_hold_d = 1'b1; // see RULE_06
        end
        if (!i_pwm_on && ctrl_q[`SFP_CTRL_VCE_CLAMP])
        begin
            vce_hold_d = 1'b1; // see RULE_07
        end
    end

    // Comparison runs only with PWM on and the pin released.
    assign vce_fault = i_pwm_on & ~vce_hold_d & ~o_vce_sense_clamp &
                       vce_sync_q[1]; // see RULE_02 RULE_04 RULE_14
    // An open current pin is pulled high and so reads as a fault.
    assign oc_fault  = i_pwm_on & ~oc_blanking &
                       oc_sync_q[1]; // see RULE_09 RULE_10 RULE_13 RULE_14
    assign permit_loss = permit_prev_q & ~permit_sync_q[1]; // see RULE_15

    always_comb
    begin
        events = 3'h0;
        events[`SFP_FLAG_VCE]    = vce_fault;
        events[`SFP_FLAG_OC]     = oc_fault;
        events[`SFP_FLAG_PERMIT] = permit_loss;
    end

    assign sel   = decode(i_paddr);
    assign rd_en = i_psel & i_penable & o_pready & ~i_pwrite;
    assign wr_en = i_psel & i_penable & o_pready & i_pwrite;
    assign rearm = wr_en & (sel == sfp_pkg::SFP_REG_CTRL) &
                   i_pwdata[`SFP_CTRL_REARM];

    // Control register; level selects change only in configuration.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ctrl_q <= `SFP_CTRL_RESET;
        end
        else if (wr_en && sel == sfp_pkg::SFP_REG_CTRL)
        begin
            ctrl_q[`SFP_CTRL_VCE_CLAMP] <= i_pwdata[`SFP_CTRL_VCE_CLAMP];
            if (i_config_op_state)
            begin
                ctrl_q[`SFP_CTRL_VCE_LVL] <=
                    (i_pwdata[`SFP_CTRL_VCE_LVL] == 1'b1); // see RULE_03
                ctrl_q[`SFP_CTRL_OC_LVL_HI:`SFP_CTRL_OC_LVL_LO] <=
                    i_pwdata[`SFP_CTRL_OC_LVL_HI:`SFP_CTRL_OC_LVL_LO];
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            vce_blank_q <= `SFP_BLANK_RESET;
            oc_blank_q  <= `SFP_BLANK_RESET;
            irq_en_q    <= `SFP_IRQ_EN_RESET;
        end
        else if (wr_en)
        begin
            if (sel == sfp_pkg::SFP_REG_VCE_BLANK)
            begin
                vce_blank_q <= i_pwdata[7:0];
            end
            if (sel == sfp_pkg::SFP_REG_OC_BLANK)
            begin
                oc_blank_q <= i_pwdata[7:0];
            end
            if (sel == sfp_pkg::SFP_REG_IRQ_EN)
            begin
                irq_en_q <= i_pwdata[2:0];
            end
        end
    end

    // Sticky fault flags; a new event wins over a clear.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            flags_q <= 3'h0;
        end
        else
        begin
            if (wr_en && sel == sfp_pkg::SFP_REG_FLAG_CLR)
            begin
                flags_q <= (flags_q & ~i_pwdata[2:0]) | events;
            end
            else
            begin
                flags_q <= flags_q | events; // see RULE_02 RULE_09 RULE_15
            end
        end
    end

    // The driver stays disabled until software writes the rearm bit.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            disabled_q <= 1'b0;
        end
        else if (|events)
        begin
            disabled_q <= 1'b1; // see RULE_17
        end
        else if (rearm)
        begin
            disabled_q <= 1'b0; // see RULE_17
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_safe_off_req    <= 1'b0;
            o_regular_off_req <= 1'b0;
            o_fault_a_out_b   <= 1'b1;
            o_disabled        <= 1'b0;
            o_irq             <= 1'b0;
        end
        else
        begin
            o_safe_off_req    <= vce_fault | oc_fault; // see RULE_14
            o_regular_off_req <= permit_loss;          // see RULE_15
            o_fault_a_out_b   <= ~((|events) | (disabled_q & ~rearm));
            o_disabled        <= (|events) | (disabled_q & ~rearm);
            o_irq             <= |((flags_q | events) & irq_en_q);
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_vce_sense_clamp  <= 1'b1;
            o_vce_level_select <= 1'b0;
            o_oc_level_select  <= 2'h0;
        end
        else
        begin
            o_vce_sense_clamp  <= vce_hold_d; // see RULE_01 RULE_07
            o_vce_level_select <= ctrl_q[`SFP_CTRL_VCE_LVL];
            o_oc_level_select  <=
                ctrl_q[`SFP_CTRL_OC_LVL_HI:`SFP_CTRL_OC_LVL_LO]; // see RULE_12
        end
    end

    always_comb
    begin
        rd_d = 32'h0000_0000;
        unique case (sel)
            sfp_pkg::SFP_REG_CTRL:      rd_d[3:0] = ctrl_q;
            sfp_pkg::SFP_REG_VCE_BLANK: rd_d[7:0] = vce_blank_q;
            sfp_pkg::SFP_REG_OC_BLANK:  rd_d[7:0] = oc_blank_q;
            sfp_pkg::SFP_REG_FLAGS:     rd_d[2:0] = flags_q;
            sfp_pkg::SFP_REG_FLAG_CLR:  rd_d      = 32'h0000_0000;
            sfp_pkg::SFP_REG_IRQ_EN:    rd_d[2:0] = irq_en_q;
            sfp_pkg::SFP_REG_LIVE:
            begin
                rd_d[`SFP_LIVE_VCE_CMP]  = vce_sync_q[1]; // see RULE_05
                rd_d[`SFP_LIVE_OC_CMP]   = oc_sync_q[1] &
                                           ~oc_blanking; // see RULE_11
                rd_d[`SFP_LIVE_PERMIT]   = permit_sync_q[1]; // see RULE_16
                rd_d[`SFP_LIVE_DISABLED] = disabled_q;
            end
            sfp_pkg::SFP_REG_NONE:      rd_d      = 32'h0000_0000;
        endcase
    end

    // Ready is registered from the setup cycle, so it is high in the access cycle and every access has no waits.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end
        else
        begin
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable &
                         (sel == sfp_pkg::SFP_REG_NONE);
            if (i_psel && !i_penable && !i_pwrite)
            begin
                o_prdata <= rd_d;
            end
            else if (rd_en)
            begin
                o_prdata <= 32'h0000_0000;
            end
        end
    end

endmodule

// [testbench/sfp_protect_sva.sv]
// Concurrent checks on the ports of the switch fault protection block.
`include "sfp_map.svh"

module sfp_protect_sva
(
    input wire logic        i_clock,            // Clock.
    input wire logic        i_rst_b,            // Reset, low.
    input wire logic        i_psel,             // APB select.
    input wire logic        i_penable,          // APB enable.
    input wire logic        i_pwrite,           // APB write.
    input wire logic [11:0] i_paddr,            // APB address.
    input wire logic [31:0] i_pwdata,           // APB write data.
    input wire logic        o_pready,           // APB ready.
    input wire logic        o_pslverr,          // APB error.
    input wire logic        i_pwm_on,           // PWM on command.
    input wire logic        i_hard_off_start,   // Hard off pulse.
    input wire logic        i_config_op_state,  // Configuration state.
    input wire logic        i_ext_permit,       // Permit pin.
    input wire logic        o_vce_sense_clamp,  // Sense pin hold.
    input wire logic        o_vce_level_select, // Saturation level.
    input wire logic [1:0]  o_oc_level_select,  // Overcurrent level.
    input wire logic        o_safe_off_req,     // Safe off pulse.
    input wire logic        o_regular_off_req,  // Regular off pulse.
    input wire logic        o_fault_a_out_b,    // Fault output, low.
    input wire logic        o_disabled          // Disabled.
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic rearm_wr = i_psel && i_penable && i_pwrite && o_pready &&
        i_paddr == `SFP_OFF_CTRL && i_pwdata[`SFP_CTRL_REARM];
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_turn_on;
        $rose(i_pwm_on);
    endsequence
    sequence s_trip;
        o_safe_off_req || o_regular_off_req;
    endsequence
    AST_READY_AFTER_SETUP: assert property (s_setup |=> o_pready)
        else $error("ready missing in access cycle");
    AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    AST_HOLD_AT_TURN_ON: assert property (
        s_turn_on |=> o_vce_sense_clamp)
        else $error("sense pin not held after turn-on");
    AST_HARD_OFF_HOLD: assert property (
        i_hard_off_start |-> ##3 o_vce_sense_clamp [*8])
        else $error("sense pin released during hard off extension");
    AST_NO_TRIP_WHILE_OFF: assert property (
        !i_pwm_on [*4] |=> !o_safe_off_req)
        else $error("safe off raised while output off");
    AST_NO_LOSS_NO_TRIP: assert property (
        i_ext_permit [*6] |=> !o_regular_off_req)
        else $error("regular off without permit loss");
    AST_TRIP_DISABLES: assert property (
        s_trip |-> ##[0:2] o_disabled)
        else $error("trip did not disable");
    AST_FAULT_PIN_MATCH: assert property (
        o_fault_a_out_b != o_disabled)
        else $error("fault output disagrees with disabled");
    AST_STAYS_DISABLED: assert property (
        o_disabled && !rearm_wr |=> o_disabled)
        else $error("disabled cleared without rearm");
    AST_LEVEL_CFG_ONLY: assert property (
        !i_config_op_state [*3] |=> $stable(o_vce_level_select) &&
        $stable(o_oc_level_select))
        else $error("level select changed outside configuration");
endmodule

bind sfp_protect sfp_protect_sva chk_u (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_pwm_on(i_pwm_on),
    .i_hard_off_start(i_hard_off_start), .i_ext_permit(i_ext_permit),
    .i_config_op_state(i_config_op_state),
    .o_vce_sense_clamp(o_vce_sense_clamp),
    .o_vce_level_select(o_vce_level_select),
    .o_oc_level_select(o_oc_level_select), .o_safe_off_req(o_safe_off_req),
    .o_regular_off_req(o_regular_off_req),
    .o_fault_a_out_b(o_fault_a_out_b), .o_disabled(o_disabled));

// [testbench/sfp_sense_model.sv]
// Behavioural switch sense network and external permit source.
module sfp_sense_model
(
    input  wire logic i_vce_clamp, // Sense pin held low.
    input  wire logic i_short,     // Switch desaturated.
    input  wire logic i_over,      // Emitter current too high.
    input  wire logic i_open,      // Current sense input open.
    input  wire logic i_valid,     // Permit source valid.
    output logic      o_vce_cmp,   // Saturation comparator.
    output logic      o_oc_cmp,    // Overcurrent comparator.
    output logic      o_ext_permit // Permit pin.
);
    timeunit 1ns;
    timeprecision 1ps;
    // A held pin reads below threshold whatever the switch does.
    assign o_vce_cmp = i_short & ~i_vce_clamp;
    // The pull-up lifts an open input above the threshold.
    assign o_oc_cmp = i_over | i_open;
    assign o_ext_permit = i_valid;
endmodule

// [testbench/test_switch_fault_protection.sv]
// Self-checking bench for the switch fault protection block.
`include "sfp_map.svh"

module test_switch_fault_protection;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] all_bits = 32'hFFFF_FFFF;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel, penable, pwrite, pwm_on, plateau, hard_off, cfg_st;
    logic        short_vce, over, open_oc, valid, rd_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic        pready, pslverr, vce_cmp, oc_cmp, permit, clamp, vlvl;
    logic [1:0]  oclvl;
    logic        safe_off, reg_off, fault_b, disabled, irq;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          t0, el;
    always #2 clk = ~clk;
    sfp_protect dut_u (.i_clock(clk), .i_rst_b(rst_b), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_pwm_on(pwm_on),
        .i_two_level_turnoff(plateau), .i_hard_off_start(hard_off),
        .i_config_op_state(cfg_st), .i_vce_cmp(vce_cmp), .i_oc_cmp(oc_cmp),
        .i_ext_permit(permit), .o_vce_sense_clamp(clamp),
        .o_vce_level_select(vlvl), .o_oc_level_select(oclvl),
        .o_safe_off_req(safe_off), .o_regular_off_req(reg_off),
        .o_fault_a_out_b(fault_b), .o_disabled(disabled), .o_irq(irq));
    sfp_sense_model model_u (.i_vce_clamp(clamp), .i_short(short_vce),
        .i_over(over), .i_open(open_oc), .i_valid(valid),
        .o_vce_cmp(vce_cmp), .o_oc_cmp(oc_cmp), .o_ext_permit(permit));
    task automatic final_report();
        if (mismatches == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        apb(a, 1'h0, 32'h0);
        check(rd_data & m, exp);
    endtask
    task automatic irq_step(input logic [11:0] a, input logic [31:0] d,
                            input logic [31:0] exp);
        apb(a, 1'h1, d);
        repeat (3) @(posedge clk);
        check(irq, exp);
    endtask
    task automatic wait_off();
        while (safe_off !== 1'b1 && reg_off !== 1'b1)
        begin
            @(posedge clk);
        end
    endtask
    // A hang ends the run as a failure.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            mismatches++;
            final_report();
        end
    end
    initial
    begin
        {psel, penable, pwrite, pwm_on, plateau, hard_off, cfg_st} = 7'h00;
        {short_vce, over, open_oc, valid} = 4'h1;
        paddr  = 12'h000;
        pwdata = 32'h0;
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        rd_chk(`SFP_OFF_VCE_BLANK, all_bits, 32'h10);
        rd_chk(`SFP_OFF_OC_BLANK, all_bits, 32'h10);
        rd_chk(`SFP_OFF_FLAGS, all_bits, 32'h0);
        rd_chk(`SFP_OFF_IRQ_EN, all_bits, 32'h0);
        rd_chk(12'h01C, all_bits, 32'h0);
        check(rd_err, 32'h1);
        cfg_st <= 1'h1;
        for (int v = 0; v < 4; v++)
        begin
            apb(`SFP_OFF_CTRL, 1'h1, 32'(v * 4 + v % 2));
            repeat (3) @(posedge clk);
            check({vlvl, oclvl}, 32'((v % 2) * 4 + v));
        end
        cfg_st <= 1'h0;
        apb(`SFP_OFF_VCE_BLANK, 1'h1, 32'h2);
        apb(`SFP_OFF_OC_BLANK, 1'h1, 32'h3);
        apb(`SFP_OFF_IRQ_EN, 1'h1, 32'h7);
        short_vce <= 1'h1;
        over      <= 1'h1;
        repeat (100) @(posedge clk);
        check(disabled, 32'h0);
        over   <= 1'h0;
        pwm_on <= 1'h1;
        repeat (30) @(posedge clk);
        pwm_on <= 1'h0;
        repeat (4) @(posedge clk);
        check(disabled, 32'h0);
        pwm_on <= 1'h1;
        t0 = cycles;
        repeat (10) @(posedge clk);
        check(clamp, 32'h1);
        wait_off();
        el = cycles - t0;
        check(32'(el >= 50 && el <= 62), 32'h1);
        repeat (2) @(posedge clk);
        check({fault_b, irq}, 32'h1);
        rd_chk(`SFP_OFF_FLAGS, all_bits, 32'h1);
        rd_chk(`SFP_OFF_LIVE, all_bits, 32'hD);
        pwm_on    <= 1'h0;
        short_vce <= 1'h0;
        plateau   <= 1'h1;
        repeat (4) @(posedge clk);
        check(clamp, 32'h1);
        plateau  <= 1'h0;
        hard_off <= 1'h1;
        @(posedge clk);
        hard_off <= 1'h0;
        repeat (40) @(posedge clk);
        check(clamp, 32'h1);
        repeat (20) @(posedge clk);
        check({clamp, disabled}, 32'h1);
        apb(`SFP_OFF_FLAG_CLR, 1'h1, 32'h7);
        apb(`SFP_OFF_CTRL, 1'h1, 32'h102);
        repeat (3) @(posedge clk);
        check({clamp, vlvl, oclvl, disabled, fault_b, irq}, 32'h7A);
        rd_chk(`SFP_OFF_CTRL, all_bits, 32'hF);
        for (int c = 0; c < 2; c++)
        begin
            over    <= c == 0;
            open_oc <= c == 1;
            pwm_on  <= 1'h1;
            t0 = cycles;
            // Let the raised comparator pass the synchroniser first.
            repeat (5) @(posedge clk);
            rd_chk(`SFP_OFF_LIVE, 32'h2, 32'h0);
            wait_off();
            el = cycles - t0;
            check(32'(el >= 75 && el <= 87), 32'h1);
            rd_chk(`SFP_OFF_FLAGS, all_bits, 32'h2);
            rd_chk(`SFP_OFF_LIVE, 32'hA, 32'hA);
            pwm_on  <= 1'h0;
            over    <= 1'h0;
            open_oc <= 1'h0;
            apb(`SFP_OFF_FLAG_CLR, 1'h1, 32'h7);
            apb(`SFP_OFF_CTRL, 1'h1, 32'h102);
        end
        rd_chk(`SFP_OFF_LIVE, 32'hD, 32'h4);
        valid <= 1'h0;
        wait_off();
        check({safe_off, reg_off}, 32'h1);
        repeat (2) @(posedge clk);
        check({fault_b, irq}, 32'h1);
        apb(`SFP_OFF_FLAGS, 1'h1, 32'h0);
        rd_chk(`SFP_OFF_FLAGS, all_bits, 32'h4);
        rd_chk(`SFP_OFF_LIVE, 32'h4, 32'h0);
        irq_step(`SFP_OFF_IRQ_EN, 32'h3, 32'h0);
        irq_step(`SFP_OFF_IRQ_EN, 32'h4, 32'h1);
        irq_step(`SFP_OFF_FLAG_CLR, 32'h4, 32'h0);
        final_report();
    end
endmodule
